// [dv/flash_cmd_host_tb.sv]
// self-checking bench for the flash command host
`include "flash_host_cfg.svh"
`default_nettype none
module flash_cmd_host_tb import flash_host_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
    logic        clk, rst_n, hwrite, hready, hresp, fready, susp, byp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  fdq, d;
    logic [21:0] a;
    logic [15:0] lfsr;
    logic [30:0] exq[$];
    flash_pins_s pins;
    int          errors, num_checks;
    logic [3:0]  ops[15] = '{4'h3, 4'h4, 4'h2, 4'h1, 4'h0, 4'h5, 4'h8, 4'h9,
        4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'hf};
    flash_cmd_host flash_cmd_host_i (.core_clk_in(clk), .rst_n_in(rst_n),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'b010), .hwdata_in(hwdata), .hsel_in(1'b1),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .flash_out(pins), .flash_dq_in(fdq),
        .operation_done_input_in(fready));
    flash_dev_model #(.MAKER_CODE(MAKER)) flash_dev_model_i (
        .core_clk_in(clk), .flash_in(pins), .dq_out(fdq), .ready_out(fready));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #9000000;
        errors++;
        complete_run();
    end
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        haddr <= {24'h0, ad};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic put(input logic x, input logic [21:0] pa, input logic [7:0] pd);
        exq.push_back({x, pa, pd});
    endtask
    task automatic unl();
        put(0, `UNLOCK_ADDR1, 8'haa);
        put(0, `UNLOCK_ADDR2, 8'h55);
    endtask
    task automatic run(input logic [3:0] op);
        int n;
        flash_dev_model_i.wlog.delete();
        ahb(1, 8'h00, {28'h0, op});
        n = 0;
        do begin
            ahb(0, 8'h0c, 0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        check(n < 400, 1);
        check(flash_dev_model_i.wlog.size(), exq.size());
        foreach (exq[i])
            check(exq[i][30] ? flash_dev_model_i.wlog[i][7:0]
                             : flash_dev_model_i.wlog[i],
                  exq[i][30] ? exq[i][7:0] : exq[i][29:0]);
        exq.delete();
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0; htrans = 2'b00; haddr = 0; hwrite = 0; hwdata = 0;
        lfsr = 16'd20125; errors = 0; num_checks = 0; susp = 0; byp = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ahb(0, 8'h0c, 0); check(rd, 32'h20);
        ahb(0, 8'h10, 0); check(rd, 0);
        foreach (ops[k]) begin
            lfsr = step(lfsr); a = {lfsr[5:0], lfsr};
            lfsr = step(lfsr); d = lfsr[7:0];
            if (ops[k] == 4'h2) a[7:0] = 8'h00;
            ahb(1, 8'h04, {10'h0, a});
            ahb(1, 8'h08, {24'h0, d});
            ahb(0, 8'h04, 0); check(rd, {10'h0, a});
            case (ops[k])
                4'h1: put(1, 0, 8'hf0);
                4'h2: begin unl(); put(0, `UNLOCK_ADDR1, 8'h90); end
                4'h3: begin unl(); put(0, `UNLOCK_ADDR1, 8'h88); end
                4'h4: begin unl(); put(0, `UNLOCK_ADDR1, 8'h90); put(1, 0, 8'h00); end
                4'h5: begin unl(); put(0, `UNLOCK_ADDR1, 8'ha0); put(0, a, d); end
                4'h8: begin unl(); put(0, `UNLOCK_ADDR1, 8'hf0); end
                4'h9: begin unl(); put(0, `UNLOCK_ADDR1, 8'h20); byp = 1; end
                4'ha: begin put(1, 0, 8'ha0); put(0, a, d); end
                4'hb: begin put(1, 0, 8'h90); put(1, 0, 8'h00); byp = 0; end
                4'hc: begin unl(); put(0, `UNLOCK_ADDR1, 8'h80); unl(); put(0, `UNLOCK_ADDR1, 8'h10); end
                4'hd: begin unl(); put(0, `UNLOCK_ADDR1, 8'h80); unl(); put(0, a, 8'h30); end
                4'he: begin put(1, 0, 8'hb0); susp = 1; end
                4'hf: if (susp) begin put(1, 0, 8'h30); susp = 0; end else put(0, `CFI_ADDR, 8'h98);
                default: ;
            endcase
            run(ops[k]);
            check(rd[4:3], {susp, byp});
            ahb(0, 8'h10, 0);
            if (ops[k] == 4'h0) check(rd, {24'h0, a[7:0] ^ 8'h5a});
            if (ops[k] == 4'h2) check(rd, {24'h0, MAKER});
        end
        lfsr = step(lfsr); a = {lfsr[5:0], lfsr};
        ahb(1, 8'h04, {10'h0, a});
        ahb(1, 8'h14, {29'h0, lfsr[10:8]});
        unl(); put(0, a, 8'h25); put(0, a, {5'h0, lfsr[10:8]});
        for (int i = 0; i <= int'(lfsr[10:8]); i++) begin
            d = 8'(step(16'(lfsr + 16'(i))));
            ahb(1, 8'h08, {24'h0, d});
            put(0, {a[21:5], a[4:0] + 5'(i)}, d);
        end
        run(4'h6);
        put(0, a, 8'h29); run(4'h7);
        run(4'ha); check(rd[2], 1'b1);
        ahb(1, 8'h14, 32'd32);
        run(4'h6); check(rd[2], 1'b1);
        ahb(0, 8'h40, 0); check(rd, 0);
        check(hresp, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire

// [dv/flash_dev_model.sv]
// behavioural byte-mode flash device on the far side of the host
`default_nettype none
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
    parameter logic [7:0] PART_CODE  = 8'h4d, // arbitrary value
    parameter int         BUSY_CYC   = 12
) (
    input  wire logic        core_clk_in,
    input  wire flash_pins_s flash_in,
    output logic      [7:0]  dq_out,
    output logic             ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [29:0] wlog[$];
    logic [7:0]  prev_d = 8'h00;
    logic [7:0]  last_q = 8'h00;
    logic        ident  = 1'b0;
    int          busy_cnt = 0;
    // ===============================================
    // write cycles: data taken at the rising write strobe while chip select is low
    always @(posedge flash_in.we_n) if (!flash_in.ce_n) begin
        wlog.push_back({flash_in.addr, flash_in.dq});
        if (flash_in.dq == 8'h90 && prev_d == 8'h55) ident = 1'b1;
        if (flash_in.dq inside {8'hf0, 8'h00}) ident = 1'b0;
        if (prev_d == 8'haa && flash_in.dq != 8'h55) ident = 1'b0;
        if (prev_d == 8'ha0 || flash_in.dq == 8'h29 ||
            (prev_d == 8'h55 && flash_in.dq inside {8'h10, 8'h30}))
            busy_cnt = BUSY_CYC;
        prev_d = flash_in.dq;
    end
    always @(posedge core_clk_in) if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    assign ready_out = (busy_cnt == 0);
    // ===============================================
    // read cycles; released bus shows the inverse of the last byte
    always @(posedge flash_in.oe_n) last_q <= dq_out;
    always_comb begin
        dq_out = ~last_q;
        if (!flash_in.ce_n && !flash_in.oe_n) begin
            dq_out = flash_in.addr[7:0] ^ 8'h5a;
            if (ident) begin
                case (flash_in.addr[7:0])
                    8'h00: dq_out = MAKER_CODE;
                    8'h02: dq_out = PART_CODE;
                    8'h06: dq_out = 8'h18;
                    8'h04: dq_out = 8'h00;
                    default: dq_out = 8'h01;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [shared/flash_host_cfg.svh]
// constants for the byte-mode flash command host
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// ==========================================================
// register map (byte addresses)
`define REG_CMD       8'h00
`define REG_ADDR      8'h04
`define REG_DATA      8'h08
`define REG_STATUS    8'h0c
`define REG_RDATA     8'h10
`define REG_COUNT     8'h14

// ==========================================================
// command codes
`define OP_READ       4'h0
`define OP_RESET      4'h1
`define OP_IDENT      4'h2
`define OP_SEC_ENTER  4'h3
`define OP_SEC_EXIT   4'h4
`define OP_PROGRAM    4'h5
`define OP_BUF_WRITE  4'h6
`define OP_BUF_CONF   4'h7
`define OP_ABORT_RST  4'h8
`define OP_BYP_ENTER  4'h9
`define OP_BYP_PROG   4'ha
`define OP_BYP_EXIT   4'hb
`define OP_CHIP_ERASE 4'hc
`define OP_SECT_ERASE 4'hd
`define OP_SUSPEND    4'he
`define OP_CFI_RESUME 4'hf

// ==========================================================
// flash bytes and addresses
`define UNLOCK_ADDR1  22'h000aaa
`define UNLOCK_ADDR2  22'h000555
`define CFI_ADDR      22'h0000aa
`define D_UNLOCK1     8'haa
`define D_UNLOCK2     8'h55
`define D_RESET       8'hf0
`define D_IDENT       8'h90
`define D_SEC_ENTER   8'h88
`define D_EXIT_DATA   8'h00
`define D_PROGRAM     8'ha0
`define D_BUF_LOAD    8'h25
`define D_BUF_CONF    8'h29
`define D_BYPASS      8'h20
`define D_ERASE_SETUP 8'h80
`define D_CHIP_ERASE  8'h10
`define D_SECT_ERASE  8'h30
`define D_SUSPEND     8'hb0
`define D_RESUME      8'h30
`define D_CFI         8'h98
`define BUF_MAX_BYTES 6'd32
`define SEQ_MAX_CYC   6'd37

// ==========================================================
// strobe timing, in cycles of the 100 ns clock
`define STROBE_NS     100
`define CLK_NS        100
`define STROBE_CYC    ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [shared/flash_host_pkg.sv]
// types shared by the flash command host
`default_nettype none
package flash_host_pkg;
    typedef struct packed {
        logic        we_n;
        logic        oe_n;
        logic        ce_n;
        logic [21:0] addr;
        logic [7:0]  dq;
        logic        dq_oe_n;
    } flash_pins_s;

    typedef struct packed {
        logic       busy;
        logic       error;
        logic       ready;
        logic       bypass;
        logic       suspended;
    } host_stat_s;
endpackage
`default_nettype wire

// [verilog/flash_cmd_host.sv]
// ahb-lite controller that issues byte-mode flash command sequences
`include "flash_host_cfg.svh"
`default_nettype none
// Notes on behaviour
// - unlock writes AA at AAA, 55 at 555
// - F0 anywhere returns to read mode
// - identify: unlock, 90 at AAA, then read
// - id codes read at X00, X02, X1C, X1E
// - 88 enters region; 90 then 00 exits
// - buffer: 25, count-1, then address/data pairs
// - buffered sequence at most 37 cycles
// - 29 at sector starts buffer programming
// - abort recovery: unlock then F0 at AAA
// - 20 after unlock enters bypass mode
// - bypass program: A0 then data
// - bypass exit: 90 then 00
// - erase: six writes, 10 chip, 30 sector
// - B0 suspends; erase only for sector; host sends B0 and sets susp_reg on every OP_SUSPEND, with or without an erase
// - 30 resumes only during erase suspend
// - 98 at AA enters query mode
module flash_cmd_host
    import flash_host_pkg::*;
#(
    parameter int BUF_DEPTH = 32
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hsel_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output flash_pins_s      flash_out,
    input  wire logic [7:0]  flash_dq_in,
    input  wire logic        operation_done_input_in
);
    // ======================================================
    // sequence engine states
    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_SETUP = 6'b000010,
        S_PULSE = 6'b000100,
        S_HOLD  = 6'b001000,
        S_RSAMP = 6'b010000,
        S_NEXT  = 6'b100000
    } seq_e;

    seq_e        state_reg;
    logic [3:0]  op_reg;
    logic [21:0] addr_reg;
    logic [7:0]  data_reg;
    logic [7:0]  rdata_reg;
    logic [5:0]  count_reg;
    logic [5:0]  step_reg;
    logic [5:0]  slot_reg;
    logic [1:0]  tcnt_reg;
    logic        bypass_reg;
    logic        susp_reg;
    logic        error_reg;
    logic        ahb_wr_reg;
    logic [7:0]  ahb_addr_reg;
    logic [7:0]  slot_rd;
    logic        cyc_write;
    logic [21:0] cyc_addr;
    logic [7:0]  cyc_data;
    logic        cyc_last;
    logic [5:0]  bc_total;

    // ======================================================
    // helpers
    function automatic logic [21:0] page_addr(input logic [21:0] a,
                                              input logic [5:0]  i);
        return {a[21:5], 5'(a[4:0] + i[4:0])};
    endfunction

    function automatic logic [5:0] seq_len(input logic [3:0] op,
                                           input logic [5:0] bc);
        case (op)
            `OP_READ, `OP_RESET, `OP_BUF_CONF,
            `OP_SUSPEND:                       return 6'd1;
            `OP_BYP_PROG, `OP_BYP_EXIT:        return 6'd2;
            `OP_SEC_ENTER, `OP_ABORT_RST,
            `OP_BYP_ENTER:                     return 6'd3;
            `OP_IDENT, `OP_SEC_EXIT,
            `OP_PROGRAM:                       return 6'd4;
            `OP_CHIP_ERASE, `OP_SECT_ERASE:    return 6'd6;
            `OP_BUF_WRITE:                     return 6'(bc + 6'd5);
            default:                           return 6'd1;
        endcase
    endfunction

    assign bc_total = seq_len(op_reg, count_reg);

    slot_buffer #(.DEPTH(BUF_DEPTH), .AW(5)) u_slots (
        .core_clk_in (core_clk_in),
        .wr_en_in    (ahb_wr_reg && ahb_addr_reg == `REG_DATA
                      && state_reg == S_IDLE),
        .wr_idx_in   (slot_reg[4:0]),
        .wr_data_in  (hwdata_in[7:0]),
        .rd_idx_in   (5'(step_reg - 6'd3)),
        .rd_data_out (slot_rd)
    );

    // ======================================================
    // per-cycle address and data of the current bus cycle
    always_comb begin
        cyc_write = 1'b1;
        cyc_addr  = addr_reg;
        cyc_data  = data_reg;
        if (op_reg != `OP_BYP_PROG && op_reg != `OP_BYP_EXIT
            && op_reg != `OP_READ && op_reg != `OP_RESET
            && op_reg != `OP_BUF_CONF && op_reg != `OP_SUSPEND
            && op_reg != `OP_CFI_RESUME
            && (step_reg == 6'd0 || step_reg == 6'd1
                || (step_reg >= 6'd3 && step_reg <= 6'd4
                    && (op_reg == `OP_CHIP_ERASE
                        || op_reg == `OP_SECT_ERASE)))) begin
            if (step_reg == 6'd0 || step_reg == 6'd3) begin
                cyc_addr = `UNLOCK_ADDR1;
                cyc_data = `D_UNLOCK1;
            end else begin
                cyc_addr = `UNLOCK_ADDR2;
                cyc_data = `D_UNLOCK2;
            end
        end else begin
            case (op_reg)
                `OP_READ: begin
                    cyc_write = 1'b0;
                end
                `OP_RESET:     cyc_data = `D_RESET;
                `OP_IDENT: begin
                    if (step_reg == 6'd2) begin
                        cyc_addr = `UNLOCK_ADDR1;
                        cyc_data = `D_IDENT;
                    end else begin
                        cyc_write = 1'b0;
                    end
                end
                `OP_SEC_ENTER: begin
                    cyc_addr = `UNLOCK_ADDR1;
                    cyc_data = `D_SEC_ENTER;
                end
                `OP_SEC_EXIT: begin
                    if (step_reg == 6'd2) begin
                        cyc_addr = `UNLOCK_ADDR1;
                        cyc_data = `D_IDENT;
                    end else begin
                        cyc_data = `D_EXIT_DATA;
                    end
                end
                `OP_PROGRAM: begin
                    if (step_reg == 6'd2) begin
                        cyc_addr = `UNLOCK_ADDR1;
                        cyc_data = `D_PROGRAM;
                    end
                end
                `OP_BUF_WRITE: begin
                    if (step_reg == 6'd2) begin
                        cyc_data = `D_BUF_LOAD;
                    end else if (step_reg == 6'd3) begin
                        cyc_data = 8'(count_reg);
                    end else begin
                        cyc_addr = page_addr(addr_reg, 6'(step_reg - 6'd4));
                        cyc_data = slot_rd;
                    end
                end
                `OP_BUF_CONF:  cyc_data = `D_BUF_CONF;
                `OP_ABORT_RST: begin
                    cyc_addr = `UNLOCK_ADDR1;
                    cyc_data = `D_RESET;
                end
                `OP_BYP_ENTER: begin
                    cyc_addr = `UNLOCK_ADDR1;
                    cyc_data = `D_BYPASS;
                end
                `OP_BYP_PROG: begin
                    if (step_reg == 6'd0) begin
                        cyc_data = `D_PROGRAM;
                    end
                end
                `OP_BYP_EXIT: begin
                    cyc_data = (step_reg == 6'd0) ? `D_IDENT
                                                  : `D_EXIT_DATA;
                end
                `OP_CHIP_ERASE, `OP_SECT_ERASE: begin
                    cyc_addr = `UNLOCK_ADDR1;
                    if (step_reg == 6'd2) begin
                        cyc_data = `D_ERASE_SETUP;
                    end else if (op_reg == `OP_CHIP_ERASE) begin
                        cyc_data = `D_CHIP_ERASE;
                    end else begin
                        cyc_addr = addr_reg;
                        cyc_data = `D_SECT_ERASE;
                    end
                end
                `OP_SUSPEND:   cyc_data = `D_SUSPEND;
                default: begin
                    // resume when suspended, query otherwise
                    if (susp_reg) begin
                        cyc_data = `D_RESUME;
                    end else begin
                        cyc_addr = `CFI_ADDR;
                        cyc_data = `D_CFI;
                    end
                end
            endcase
        end
        cyc_last = (step_reg == 6'(bc_total - 6'd1));
    end

    // ======================================================
    // ahb-lite slave, zero wait states, including while a sequence runs
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ahb_wr_reg   <= 1'b0;
            ahb_addr_reg <= 8'h00;
        end else if (hready_in) begin
            ahb_wr_reg   <= hsel_in && htrans_in[1] && hwrite_in;
            ahb_addr_reg <= haddr_in[7:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
            if (haddr_in[7:0] == `REG_STATUS) begin
                hrdata_out <= {26'h0, operation_done_input_in, susp_reg,
                               bypass_reg, error_reg, 1'b0,
                               state_reg != S_IDLE};
            end else if (haddr_in[7:0] == `REG_RDATA) begin
                hrdata_out <= {24'h0, rdata_reg};
            end else if (haddr_in[7:0] == `REG_ADDR) begin
                hrdata_out <= {10'h0, addr_reg};
            end else if (haddr_in[7:0] == `REG_COUNT) begin
                hrdata_out <= {26'h0, count_reg};
            end else begin
                hrdata_out <= 32'h0000_0000;
            end
        end
    end

    // ======================================================
    // command register writes and the sequence engine
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_reg  <= S_IDLE;
            op_reg     <= `OP_READ;
            addr_reg   <= 22'h0;
            data_reg   <= 8'h00;
            rdata_reg  <= 8'h00;
            count_reg  <= 6'd0;
            step_reg   <= 6'd0;
            slot_reg   <= 6'd0;
            tcnt_reg   <= 2'd0;
            bypass_reg <= 1'b0;
            susp_reg   <= 1'b0;
            error_reg  <= 1'b0;
            flash_out  <= '{we_n: 1'b1, oe_n: 1'b1, ce_n: 1'b1,
                           addr: 22'h0, dq: 8'h00, dq_oe_n: 1'b1};
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (ahb_wr_reg && ahb_addr_reg == `REG_ADDR) begin
                        addr_reg <= hwdata_in[21:0];
                    end else if (ahb_wr_reg && ahb_addr_reg == `REG_DATA) begin
                        data_reg <= hwdata_in[7:0];
                        slot_reg <= 6'(slot_reg + 6'd1);
                    end else if (ahb_wr_reg && ahb_addr_reg == `REG_COUNT) begin
                        count_reg <= hwdata_in[5:0];
                        slot_reg  <= 6'd0;
                    end else if (ahb_wr_reg && ahb_addr_reg == `REG_CMD) begin
                        op_reg   <= hwdata_in[3:0];
                        step_reg <= 6'd0;
                        if ((hwdata_in[3:0] == `OP_BUF_WRITE
                             && (count_reg >= `BUF_MAX_BYTES
                                 || 6'(count_reg + 6'd5) > `SEQ_MAX_CYC))
                            || (hwdata_in[3:0] == `OP_BYP_PROG && !bypass_reg)
                            || (hwdata_in[3:0] == `OP_BYP_EXIT
                                && !bypass_reg)) begin
                            error_reg <= 1'b1;
                        end else begin
                            error_reg <= 1'b0;
                            state_reg <= S_SETUP;
                            tcnt_reg  <= 2'd0;
                        end
                    end
                end
                S_SETUP: begin
                    flash_out.addr    <= cyc_addr;
                    flash_out.dq      <= cyc_data;
                    flash_out.dq_oe_n <= !cyc_write;
                    flash_out.ce_n    <= 1'b0;
                    state_reg         <= S_PULSE;
                end
                S_PULSE: begin
                    // strobe falls here; device latches address and data on its rising edge
                    flash_out.we_n <= !cyc_write;
                    flash_out.oe_n <= cyc_write;
                    tcnt_reg       <= 2'd0;
                    state_reg      <= S_HOLD;
                end
                S_HOLD: begin
                    if (tcnt_reg >= 2'(`STROBE_CYC - 1)) begin
                        // we rises before ce so data latch is on we
                        flash_out.we_n <= 1'b1;
                        state_reg      <= S_RSAMP;
                    end else begin
                        tcnt_reg <= 2'(tcnt_reg + 2'd1);
                    end
                end
                S_RSAMP: begin
                    if (!cyc_write) begin
                        rdata_reg <= flash_dq_in;
                    end
                    flash_out.oe_n    <= 1'b1;
                    flash_out.ce_n    <= 1'b1;
                    flash_out.dq_oe_n <= 1'b1;
                    state_reg         <= S_NEXT;
                end
                default: begin
                    if (cyc_last) begin
                        state_reg <= S_IDLE;
                        case (op_reg)
                            `OP_BYP_ENTER: bypass_reg <= 1'b1;
                            `OP_BYP_EXIT:  bypass_reg <= 1'b0;
                            `OP_SUSPEND:   susp_reg   <= 1'b1;
                            `OP_RESET:     susp_reg   <= susp_reg;
                            `OP_CFI_RESUME: begin
                                if (susp_reg) begin
                                    susp_reg <= 1'b0;
                                end
                            end
                            default: ;
                        endcase
                    end else begin
                        step_reg  <= 6'(step_reg + 6'd1);
                        state_reg <= S_SETUP;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // checks
    strobe_excl_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        !(flash_out.we_n == 1'b0 && flash_out.oe_n == 1'b0))
        else $error("write and read strobes both active");
    drive_on_write_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        !flash_out.we_n |-> !flash_out.dq_oe_n && !flash_out.ce_n)
        else $error("write strobe without data drive");
    we_first_rise_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        $rose(flash_out.we_n) |-> !flash_out.ce_n)
        else $error("chip select rose before write strobe");
    unlock_first_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (state_reg == S_PULSE && step_reg == 6'd0
         && op_reg == `OP_PROGRAM) |->
        flash_out.addr == `UNLOCK_ADDR1 && flash_out.dq == `D_UNLOCK1)
        else $error("program did not start with unlock");
    buf_limit_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        op_reg == `OP_BUF_WRITE |-> step_reg < `SEQ_MAX_CYC)
        else $error("buffered sequence too long");
    bypass_gate_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (state_reg == S_SETUP && op_reg == `OP_BYP_PROG) |-> bypass_reg)
        else $error("bypass program outside bypass");
    erase_final_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (state_reg == S_PULSE && op_reg == `OP_SECT_ERASE
         && step_reg == 6'd5) |->
        flash_out.dq == `D_SECT_ERASE && flash_out.addr == addr_reg)
        else $error("sector erase last cycle wrong");
    resume_gate_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (state_reg == S_PULSE && op_reg == `OP_CFI_RESUME
         && flash_out.dq == `D_RESUME) |-> susp_reg)
        else $error("resume issued while not suspended");
endmodule
`default_nettype wire

// [verilog/slot_buffer.sv]
// byte store for buffered write data, registered read port
`default_nettype none
module slot_buffer #(
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic          core_clk_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_idx_in,
    input  wire logic [7:0]    wr_data_in,
    input  wire logic [AW-1:0] rd_idx_in,
    output logic      [7:0]    rd_data_out
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge core_clk_in) begin
        if (wr_en_in) begin
            mem[wr_idx_in] <= wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        rd_data_out <= mem[rd_idx_in];
    end
endmodule
`default_nettype wire
